// >>> src/srb_pkg.sv
// Package for the static RAM board controller: sizes, map and timing.
// Assumes a 16-bit host bus with byte addresses and a 40 MHz board clock.
package srb_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BANKS = 4;
  localparam int unsigned BANK_BYTES = 4096;
  localparam int unsigned BANK_WORDS = BANK_BYTES / 2;
  localparam int unsigned WORD_AW = 11;
  localparam int unsigned BANK_SEL_LSB = 12;
  localparam int unsigned MAP_COUNT = 16;
  localparam int unsigned MAP_SEL_W = 4;
  localparam int unsigned MAP_ALIGN_BYTES = 8192;
  localparam int unsigned MAP_ALIGN_LSB = 13;
  localparam int unsigned ARRAY_W_BITS = 14;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RAM_ACCESS_NS = 450;
  localparam int unsigned CYCLE_NS = 1000;
  localparam int unsigned HOST_CLK_HZ = 3000000;
  localparam int unsigned CYC_NS_X1000 = 1000000000 / (CLK_HZ / 1000);
  localparam int unsigned CYCLE_CLKS_RAW = CYCLE_NS * 1000 / CYC_NS_X1000;
  localparam int unsigned CYCLE_CLKS = (CYCLE_CLKS_RAW < 1) ? 1 : CYCLE_CLKS_RAW;
  localparam int unsigned ACCESS_MAX_CLKS = 3;

  typedef struct packed {
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srb_req_s;

  typedef struct packed {
    logic sel;
    logic wait_rq;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } srb_rsp_s;

  typedef enum logic [1:0] {
    SRB_IDLE = 2'b00,
    SRB_WAIT = 2'b01,
    SRB_DONE = 2'b10
  } srb_state_e;

  typedef struct packed {
    srb_state_e st;
    logic wait_rq;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } srb_regs_s;

  localparam srb_regs_s REGS_RST = '{st: SRB_IDLE, wait_rq: 1'b0,
                                     rvalid: 1'b0, rdata: 16'h0000};
endpackage

// >>> src/srb_ctrl.sv
// Static RAM board controller: map decode, four 4K-byte banks, wait state.
// Assumes host requests are synchronous to clock and held until answered.
`timescale 1ns/1ps

// Overview of operation
// - The RAM is four banks of 4K bytes each, 16K bytes in all.
// - A static 4-bit switch value picks one of eight placements, each reached by two settings.
// - Every placement starts on an 8K-byte aligned host address.
// - With the wait option fitted each access is stretched one clock.
// - A static jumper removes the wait clock for faster RAM.
// - A whole memory cycle fits in one microsecond at a 3 MHz bus.
module srb_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [srb_pkg::MAP_SEL_W-1:0] map_sw,
  input wire logic wait_jumper_n,
  input wire srb_pkg::srb_req_s host_req,
  output srb_pkg::srb_rsp_s host_rsp
);
  import srb_pkg::*;

  srb_regs_s r_q;
  srb_regs_s r_d;
  logic [DATA_W-1:0] ram [BANKS*BANK_WORDS];
  logic [2:0] slot;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] rel;
  logic [ARRAY_W_BITS-1:0] off;
  logic [WORD_AW+1:0] widx;
  logic [1:0] bank;
  logic hit;
  logic wait_en;

  // window decode.
  // Bits 2..0 of the switches pick one of eight 8K-aligned base slots and
  // bit 3 flips the lowest slot bit, so the sixteen settings fold onto only eight distinct slots.
  // The 16K array covers the base slot and the slot after it.
  // The subtraction wraps at the top of the 64K space, so the highest slot
  // folds its upper half onto address zero instead of losing banks 2 and 3.
  // A window that only compared bits 15..13 would hide half of the RAM.
  always_comb begin
    slot = map_sw[2:0] ^ {2'b00, map_sw[3]};
    base = {slot, 13'h0000};
    rel = host_req.addr - base;
    off = rel[ARRAY_W_BITS-1:0];
    hit = host_req.req && (rel[ADDR_W-1:ARRAY_W_BITS] == 2'b00);
  end

  // bank split.
  // Byte address bit 0 is ignored, since the host moves whole words only.
  assign bank = off[ARRAY_W_BITS-1:BANK_SEL_LSB];
  assign widx = {bank, off[BANK_SEL_LSB-1:1]};
  assign wait_en = wait_jumper_n;

  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    case (r_q.st)
      SRB_IDLE: begin
        if (hit) begin
          if (wait_en) begin
            r_d.st = SRB_WAIT;
            r_d.wait_rq = 1'b1;
          end else begin
            r_d.st = SRB_DONE;
            r_d.rvalid = ~host_req.wr;
            r_d.rdata = ram[widx];
          end
        end
      end
      SRB_WAIT: begin
        r_d.st = SRB_DONE;
        r_d.wait_rq = 1'b0;
        r_d.rvalid = ~host_req.wr;
        r_d.rdata = ram[widx];
      end
      SRB_DONE: begin
        if (!host_req.req) begin
          r_d.st = SRB_IDLE;
        end
      end
      default: begin
        r_d = REGS_RST;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // The array has no reset; contents are undefined until written.
  // Writes land at the take edge, so a write needs no data path through
  // the wait state and the wait only serves slow read access.
  always_ff @(posedge clock) begin
    if (hit && host_req.wr && r_q.st == SRB_IDLE) begin
      ram[widx] <= host_req.wdata;
    end
  end

  always_comb begin
    host_rsp.sel = hit;
    host_rsp.wait_rq = hit & (r_q.wait_rq | (wait_en & r_q.st == SRB_IDLE));
    host_rsp.rvalid = r_q.rvalid;
    host_rsp.rdata = r_q.rdata;
  end

  // a full access is at most three clocks, far inside 1 us.
  // The counter saturates so a host that never drops its request
  // cannot wrap it back into the legal range.
  logic [3:0] busy_cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 4'h0;
    end else if (r_q.st == SRB_IDLE) begin
      busy_cnt <= 4'h0;
    end else if (busy_cnt != 4'hF) begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end

  a_cycle_time_bound: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_DONE) |->
      (busy_cnt <= 4'(ACCESS_MAX_CLKS)) && (ACCESS_MAX_CLKS <= CYCLE_CLKS))
    else $error("access exceeded cycle time");
  a_wait_one_clk: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && hit && wait_jumper_n)
      |=> (r_q.st == SRB_WAIT) ##1 (r_q.st == SRB_DONE))
    else $error("wait state not exactly one clock");
  a_nowait_jumper: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && hit && !wait_jumper_n) |=> r_q.st == SRB_DONE)
    else $error("wait inserted with jumper removed");
  a_miss_silent: assert property (
    @(posedge clock) disable iff (!rst_n)
    !hit |-> (!host_rsp.sel && !host_rsp.wait_rq))
    else $error("response outside window");
  a_miss_no_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && !hit) |=> !r_q.rvalid)
    else $error("read data outside window");
  a_read_valid: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_WAIT && !host_req.wr) |=> r_q.rvalid)
    else $error("read data missing after wait");
  a_map_aligned: assert property (
    @(posedge clock) disable iff (!rst_n)
    hit |-> (host_req.addr[ADDR_W-1:MAP_ALIGN_LSB] == slot) ||
      (host_req.addr[ADDR_W-1:MAP_ALIGN_LSB] == slot + 3'h1))
    else $error("window not on aligned base");
  a_bank_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    hit |-> {1'b0, widx} < 14'(BANKS * BANK_WORDS))
    else $error("bank index out of range");
  a_wait_drop: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(r_q.wait_rq) |=> $fell(r_q.wait_rq))
    else $error("wait held too long");

  // Checks on the answer side of an access.
  // These guard the stored word, the wait request at take and the presence
  // and shape of the read pulse, which the host samples only once per access.
  a_write_store: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && hit && host_req.wr)
      |=> ram[$past(widx)] == $past(host_req.wdata))
    else $error("write data not stored");
  a_rvalid_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    r_q.rvalid |=> !r_q.rvalid)
    else $error("read valid longer than one clock");
  a_wait_req_out: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && hit && wait_jumper_n) |-> host_rsp.wait_rq)
    else $error("wait not requested at take");
  a_nowait_answer: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && hit && !wait_jumper_n && !host_req.wr)
      |=> r_q.rvalid)
    else $error("read without wait not answered");

  // The host must drop its request before the next access starts; until
  // then the block stays done and does not take the same cycle twice.
  a_done_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_DONE && host_req.req) |=> r_q.st == SRB_DONE)
    else $error("access retaken before request dropped");
  a_miss_idle: assert property (
    @(posedge clock) disable iff (!rst_n)
    (r_q.st == SRB_IDLE && !hit) |=> r_q.st == SRB_IDLE)
    else $error("access started outside window");
  a_upper_bank: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && host_req.addr[ADDR_W-1:MAP_ALIGN_LSB] != slot) |-> bank[1])
    else $error("upper slot not on upper banks");

  c_read_wait: cover property (@(posedge clock) disable iff (!rst_n)
    r_q.st == SRB_WAIT && !host_req.wr);
  c_write_wait: cover property (@(posedge clock) disable iff (!rst_n)
    r_q.st == SRB_WAIT && host_req.wr);
  c_nowait: cover property (@(posedge clock) disable iff (!rst_n)
    r_q.st == SRB_IDLE && hit && !wait_jumper_n);
  c_miss: cover property (@(posedge clock) disable iff (!rst_n)
    host_req.req && !hit);
  c_upper_bank: cover property (@(posedge clock) disable iff (!rst_n)
    hit && bank[1] && !host_req.wr);
endmodule

// >>> tb/srb_host_model.sv
// Host CPU board model: issues word reads and writes on the board bus.
// Assumes the controller answers within six clocks or not at all.
`timescale 1ns/1ps
module srb_host_model (
  input wire logic clock,
  input wire srb_pkg::srb_rsp_s host_rsp,
  output srb_pkg::srb_req_s host_req
);
  import srb_pkg::*;
  initial host_req = '0;
  task automatic access(input logic wr, input logic [15:0] a,
    input logic [15:0] wd, output logic [15:0] rd, output logic sel,
    output int n, output int w);
    bit done;
    n = 0;
    w = 0;
    done = 0;
    @(posedge clock);
    host_req <= '{req: 1'b1, wr: wr, addr: a, wdata: wd};
    #1;
    sel = host_rsp.sel;
    while (!done && n < 6) begin
      if (host_rsp.wait_rq === 1'b1) w++;
      if (wr) done = n > 0 && host_rsp.wait_rq === 1'b0;
      else done = host_rsp.rvalid === 1'b1;
      rd = host_rsp.rdata;
      if (!done) begin
        @(posedge clock);
        #1;
        n++;
      end
    end
    // Released lines show inverted values so stale data is never reused.
    @(posedge clock);
    host_req <= '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~wd};
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the static RAM board controller.
// Assumes the host model carries all bus traffic; switches are set here.
`timescale 1ns/1ps
module tb_top;
  import srb_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] map_sw = 4'h0;
  logic wait_jumper_n = 1'b1;
  srb_req_s host_req;
  srb_rsp_s host_rsp;
  int num_errors = 0;
  int checks = 0;
  logic [15:0] rd;
  logic sel;
  int n;
  int w;
  srb_ctrl dut_u (.clock(clock), .rst_n(rst_n), .map_sw(map_sw),
    .wait_jumper_n(wait_jumper_n), .host_req(host_req),
    .host_rsp(host_rsp));
  srb_host_model host_u (.clock(clock), .host_rsp(host_rsp),
    .host_req(host_req));
  initial forever #12.5 clock = ~clock;
  task automatic end_sim();
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, d);
    host_u.access(wr, a, d, rd, sel, n, w);
  endtask
  function automatic logic [15:0] base();
    return {map_sw[2:0] ^ {2'b00, map_sw[3]}, 13'h0000};
  endfunction
  task automatic t_maps();
    for (int m = 0; m < 16; m++) begin
      @(posedge clock);
      map_sw <= m[3:0];
      @(posedge clock);
      for (int b = 0; b < 4; b++) begin
        acc(1'b1, base() + 16'(b * 4096 + 2 * m), 16'(m * 16 + b));
        cmp(16'(w), 16'h0002);
      end
      for (int b = 0; b < 4; b++) begin
        acc(1'b0, base() + 16'(b * 4096 + 2 * m), 16'h0000);
        cmp({15'h0000, sel}, 16'h0001);
        cmp(16'(n), 16'h0002);
        cmp(rd, 16'(m * 16 + b));
      end
      acc(1'b1, base() + 16'h8000 + 16'(2 * m), 16'hFFFF);
      cmp({15'h0000, sel}, 16'h0000);
      cmp(16'(w), 16'h0000);
      acc(1'b0, base() + 16'h8000 + 16'(2 * m), 16'h0000);
      cmp(16'(n), 16'h0006);
      acc(1'b0, base() + 16'(2 * m), 16'h0000);
      cmp(rd, 16'(m * 16));
    end
  endtask
  task automatic t_nowait();
    @(posedge clock);
    wait_jumper_n <= 1'b0;
    acc(1'b1, base() + 16'h3FFE, 16'hA5C3);
    cmp(16'(w), 16'h0000);
    acc(1'b0, base() + 16'h3FFE, 16'h0000);
    cmp(16'(n), 16'h0001);
    cmp(rd, 16'hA5C3);
    cmp(16'((n + 1) * 25 <= 1000), 16'h0001);
  endtask
  initial begin
    #(4000 * 25);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_maps();
    t_nowait();
    end_sim();
  end
endmodule
